/* File: shared/did_pkg.sv */
package did_pkg;
    localparam int TYPE_MSB = 15;
    localparam int TYPE_LSB = 11;
    localparam logic [4:0] COND_LAST = 5'h1c;
    localparam logic [2:0] BRANCH_LAST = 3'h3;
    localparam logic [3:0] FN_NOP = 4'h6;
    localparam logic [3:0] FN_AND_TEST = 4'ha;
    localparam logic [3:0] FN_SUB_TEST = 4'hb;
    localparam logic [3:0] FN_PRODUCT = 4'h2;

    typedef enum logic [3:0] {
        did_cls_jump, did_cls_call, did_cls_short_imm, did_cls_mac_alu,
        did_cls_special, did_cls_three_op, did_cls_branch_ind,
        did_cls_qualifier, did_cls_bit_manip, did_cls_direct,
        did_cls_move, did_cls_long_imm, did_cls_cache, did_cls_undefined
    } did_class_type;

    typedef enum logic [1:0] {
        did_ptr_none, did_ptr_inc, did_ptr_index
    } did_ptr_op_type;

    typedef struct packed {
        did_class_type op_class;
        logic [4:0] type_code;
        logic [11:0] jump_target;
        logic short_to_pointer;
        logic [1:0] short_reg;
        logic [8:0] short_immediate;
        logic dest_acc;
        logic src_acc;
        logic transfer_acc_select;
        logic [3:0] mac_alu_function;
        logic rom_bit;
        logic two_operand;
        logic writes_acc;
        logic writes_product;
        logic compound_mode;
        logic [1:0] pointer_select;
        did_ptr_op_type pointer_op;
        logic [3:0] pointer_mode;
        logic [3:0] special_function;
        logic [4:0] condition_select;
        logic update_counter;
        logic [3:0] three_operand_function;
        logic [1:0] operand_pair_select;
        logic [2:0] branch_kind;
        logic soft_interrupt;
        logic [3:0] shift_unit_function;
        logic [3:0] aux_reg_select;
        logic direct_read;
        logic [3:0] direct_reg_select;
        logic [7:0] direct_offset;
        logic [5:0] move_reg_select;
        logic low_half;
        logic [6:0] cached_instr_count;
        logic [3:0] repeat_count;
        logic cache_redo;
        logic repeat_from_loop_reg;
        logic [15:0] long_immediate;
        logic next_is_branch;
        logic undefined;
    } did_decode_type;
endpackage : did_pkg

/* File: rtl/did_decoder.sv */
module did_decoder (
    input wire logic clock,
    input wire logic reset,
    input wire logic word_valid,
    input wire logic [15:0] word,
    output did_pkg::did_decode_type decoded,
    output logic decoded_valid
);
    import did_pkg::*;

    typedef enum logic [1:0] {
        did_st_first, did_st_immediate, did_st_branch
    } did_state_type;

    did_state_type state;
    did_state_type next_state;
    did_decode_type held;
    did_decode_type next_held;
    did_decode_type dec;
    logic next_valid;
    logic [4:0] t;

    always_comb begin
        t = word[TYPE_MSB:TYPE_LSB];
        dec = '0;
        dec.type_code = t;
        dec.op_class = did_cls_undefined;
        dec.dest_acc = word[10];
        dec.src_acc = word[9];
        dec.transfer_acc_select = ~word[10];
        dec.mac_alu_function = word[8:5];
        dec.rom_bit = word[4];
        dec.pointer_mode = word[3:0];
        dec.pointer_select = word[3:2];
        unique case (word[1:0])
            2'h1: dec.pointer_op = did_ptr_inc;
            2'h3: dec.pointer_op = did_ptr_index;
            default: dec.pointer_op = did_ptr_none;
        endcase
        dec.condition_select = word[4:0];
        dec.move_reg_select = word[9:4];
        unique casez (t)
            5'b0000?, 5'b1000?: begin
                dec.op_class = t[4] ? did_cls_call : did_cls_jump;
                dec.jump_target = {t[0], word[10:0]};
            end
            5'b0001?: begin
                dec.op_class = did_cls_short_imm;
                dec.short_to_pointer = t[0];
                dec.short_reg = word[10:9];
                dec.short_immediate = word[8:0];
            end
            5'b00100, 5'b00101, 5'b00110, 5'b00111, 5'b10100, 5'b10101,
            5'b10110, 5'b10111, 5'b11001, 5'b11011, 5'b11100, 5'b11101,
            5'b11111: begin
                dec.op_class = did_cls_mac_alu;
                dec.compound_mode = (t == 5'h05) || (t == 5'h15)
                    || (t == 5'h1d);
                if (dec.compound_mode) begin
                    dec.pointer_op = did_ptr_none;
                end
                dec.two_operand = (t == 5'h19) || (t == 5'h1b)
                    || (t == 5'h1d) || (t == 5'h1f);
                dec.writes_acc = !(word[8:5] == FN_NOP
                    || word[8:5] == FN_AND_TEST
                    || word[8:5] == FN_SUB_TEST
                    || word[8:5] == FN_PRODUCT);
                dec.writes_product = (word[8:5] == FN_PRODUCT)
                    || (word[8:5] == 4'h0) || (word[8:5] == 4'h1)
                    || (word[8:5] == 4'h3);
            end
            5'b1001?: begin
                dec.op_class = did_cls_special;
                dec.special_function = word[8:5];
                dec.update_counter = ~t[0];
                dec.undefined = word[4:0] > COND_LAST;
            end
            5'b11000: begin
                if (word[0]) begin
                    dec.op_class = did_cls_three_op;
                    dec.three_operand_function = word[8:5];
                    dec.operand_pair_select = word[4:3];
                    dec.transfer_acc_select = ~word[2];
                    dec.undefined = ~word[8] || (word[8:5] == 4'hc);
                end else begin
                    dec.op_class = did_cls_branch_ind;
                    dec.branch_kind = word[10:8];
                    dec.undefined = word[10:8] > BRANCH_LAST;
                end
            end
            5'b11010: begin
                dec.op_class = did_cls_qualifier;
                dec.soft_interrupt = word[10];
                dec.next_is_branch = ~word[10];
                dec.undefined = word[4:0] > COND_LAST;
            end
            5'b11110: begin
                if (!word[5]) begin
                    dec.op_class = did_cls_bit_manip;
                    dec.shift_unit_function = {word[8:6], word[4]};
                    dec.aux_reg_select = word[3:0];
                end else begin
                    dec.op_class = did_cls_direct;
                    dec.direct_read = word[10];
                    dec.direct_reg_select = word[9:6];
                    dec.direct_offset = {word[4:0], 3'h0} >> 3;
                end
            end
            5'b01000, 5'b01001, 5'b01011, 5'b01100, 5'b01101,
            5'b01111: begin
                dec.op_class = did_cls_move;
                dec.low_half = (t == 5'h08) ? word[0] : word[10];
                dec.undefined = (word[9:4] == 6'h0f) || (word[9:4] == 6'h1e)
                    || (word[9:4] == 6'h39) || (word[9:4] == 6'h3e)
                    || (word[9:6] == 4'hb);
            end
            5'b01010: begin
                dec.op_class = did_cls_long_imm;
                dec.move_reg_select = word[9:4];
            end
            5'b01110: begin
                dec.op_class = did_cls_cache;
                dec.cached_instr_count = word[10:4];
                dec.repeat_count = word[3:0];
                dec.cache_redo = word[10:4] == 7'h00;
                dec.repeat_from_loop_reg = word[3:0] == 4'h0;
            end
            default: dec.op_class = did_cls_undefined;
        endcase
    end

    // Second words: immediate completes the held word; branch follows a
    // qualifier and is decoded on its own, marked undefined unless it is a jump, call or indirect branch.
    always_comb begin
        next_state = state;
        next_held = held;
        next_valid = 1'b0;
        if (word_valid) begin
            unique case (state)
                did_st_immediate: begin
                    next_held.long_immediate = word;
                    next_valid = 1'b1;
                    next_state = did_st_first;
                end
                did_st_branch: begin
                    next_held = dec;
                    if (dec.op_class != did_cls_jump
                        && dec.op_class != did_cls_call
                        && dec.op_class != did_cls_branch_ind) begin
                        next_held.undefined = 1'b1;
                    end
                    next_valid = 1'b1;
                    next_state = did_st_first;
                end
                default: begin
                    next_held = dec;
                    if (dec.op_class == did_cls_three_op
                        || dec.op_class == did_cls_bit_manip
                        || dec.op_class == did_cls_long_imm) begin
                        next_state = did_st_immediate;
                    end else begin
                        next_valid = 1'b1;
                        if (dec.next_is_branch) begin
                            next_state = did_st_branch;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= did_st_first;
            held <= '0;
            decoded_valid <= 1'b0;
        end else begin
            state <= next_state;
            held <= next_held;
            decoded_valid <= next_valid;
        end
    end

    assign decoded = held;
endmodule : did_decoder

/* File: tb/did_fetch_model.sv */
module did_fetch_model (
    input wire logic clock,
    output logic word_valid,
    output logic [15:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        word_valid = 1'b0;
        word = 16'h0;
    end
    // Released word lines show the inverse of the last word
    task automatic idle();
        @(posedge clock);
        word_valid <= 1'b0;
        word <= ~word;
    endtask : idle
    task automatic send(input logic [15:0] w);
        @(posedge clock);
        word_valid <= 1'b1;
        word <= w;
    endtask : send
endmodule : did_fetch_model

/* File: tb/did_decoder_monitor.sv */
module did_decoder_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire logic word_valid,
    input wire logic [15:0] word,
    input did_pkg::did_decode_type decoded,
    input wire logic decoded_valid
);
    import did_pkg::*;
    logic pend, qual, two, go, next_pend, next_qual;
    logic [15:0] first, next_first;
    logic [4:0] t;
    assign t = word[15:11];
    assign two = (t == 5'h18 && word[0]) || (t == 5'h1e && !word[5])
        || t == 5'h0a;
    assign go = word_valid && !pend && !qual;
    assign next_pend = word_valid ? !pend && two : pend;
    assign next_qual = word_valid ? go && t == 5'h1a && !word[10] : qual;
    assign next_first = (word_valid && !pend) ? word : first;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pend <= 1'b0;
            qual <= 1'b0;
            first <= 16'h0;
        end else begin
            pend <= next_pend;
            qual <= next_qual;
            first <= next_first;
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_first;
        word_valid && !pend && !qual && two;
    endsequence
    sequence s_last;
        word_valid && pend;
    endsequence
    AST_PULSE: assert property (word_valid && (pend || !two) |=>
        decoded_valid) else $error("decode pulse missing");
    AST_HOLD: assert property (s_first |=> !decoded_valid)
        else $error("pulse after first of two words");
    AST_IMM: assert property (s_last |=>
        decoded.long_immediate == $past(word)) else $error("bad immediate");
    AST_BMU: assert property (s_last ##0 first[15:11] == 5'h1e |=>
        decoded.shift_unit_function == {$past(first[8:6]), $past(first[4])})
        else $error("bad shift function");
    AST_JUMP: assert property (go && word[14:12] == 3'h0 |=>
        decoded.jump_target == $past(word[11:0]) && decoded.op_class ==
        ($past(word[15]) ? did_cls_call : did_cls_jump)) else $error("bad jump");
    AST_SHORT: assert property (go && t[4:1] == 4'h1 |=>
        decoded.short_immediate == $past(word[8:0])) else $error("bad imm9");
    AST_MAC: assert property (go && t == 5'h1f |=> {decoded.dest_acc,
        decoded.src_acc, decoded.mac_alu_function, decoded.rom_bit} ==
        $past(word[10:4])) else $error("bad mac fields");
    AST_XFER: assert property (go && t == 5'h07 |=>
        decoded.transfer_acc_select != $past(word[10])) else $error("bad xfer");
    AST_COND: assert property (go && t[4:1] == 4'h9 |=>
        decoded.undefined == ($past(word[4:0]) > COND_LAST) &&
        decoded.update_counter != $past(word[11])) else $error("bad cond");
    AST_QUAL: assert property (go && t == 5'h1a |=>
        decoded.next_is_branch != $past(word[10])) else $error("bad qualifier");
endmodule : did_decoder_monitor
bind did_decoder did_decoder_monitor u_did_decoder_monitor (.clock(clock),
    .reset(reset), .word_valid(word_valid), .word(word),
    .decoded(decoded), .decoded_valid(decoded_valid));

/* File: tb/did_decoder_tb.sv */
module did_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import did_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic word_valid, decoded_valid;
    logic [15:0] word;
    did_decode_type dec;
    int errors = 0;
    int cmp_count = 0;
    always #12.5 clock = ~clock;
    did_fetch_model u_did_fetch_model (.clock(clock),
        .word_valid(word_valid), .word(word));
    did_decoder u_did_decoder (.clock(clock), .reset(reset),
        .word_valid(word_valid), .word(word), .decoded(dec),
        .decoded_valid(decoded_valid));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic issue(input logic [15:0] w);
        u_did_fetch_model.send(w);
        u_did_fetch_model.idle();
        @(negedge clock);
        chk("pulse", decoded_valid, 1'b1);
    endtask : issue
    task automatic pair(input logic [15:0] a, b, input int gap);
        u_did_fetch_model.send(a);
        repeat (gap) u_did_fetch_model.idle();
        issue(b);
    endtask : pair
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    task automatic t_reset();
        @(posedge clock);
        reset <= 1'b1;
        repeat (10) @(posedge clock);
        @(negedge clock);
        chk("rst", {decoded_valid, dec === '0}, 2'b01);
        @(posedge clock);
        reset <= 1'b0;
        $display("test reset done");
    endtask : t_reset
    task automatic t_branch();
        issue(16'h0abc);
        issue(16'h8fff);
        issue(16'hc3fe);
        chk("bk", {dec.branch_kind, dec.undefined}, 4'h6);
        issue(16'hc400);
        chk("bkr", dec.undefined, 1'b1);
        $display("test branch done");
    endtask : t_branch
    task automatic t_mac();
        issue(16'hfcd3);
        chk("ptr", {dec.pointer_select, dec.pointer_op}, 4'h2);
        issue(16'h280f);
        chk("cmp", {dec.compound_mode, dec.pointer_op}, 3'h4);
        for (int f = 0; f < 16; f++) begin
            issue({5'h1f, 2'b01, f[3:0], 5'h00});
            chk("wacc", dec.writes_acc, !(f inside {2, 6, 10, 11}));
            chk("wprod", dec.writes_product, f < 4);
        end
        $display("test mac done");
    endtask : t_mac
    task automatic t_move();
        for (int b = 0; b < 2; b++) begin
            issue({5'h07, b[0], 10'h000});
            chk("xf", dec.transfer_acc_select, !b[0]);
        end
        issue(16'h7000);
        chk("redo", {dec.cache_redo, dec.repeat_from_loop_reg,
            dec.cached_instr_count, dec.repeat_count}, 13'h1800);
        issue(16'h7015);
        chk("do", {dec.cache_redo, dec.repeat_from_loop_reg,
            dec.cached_instr_count, dec.repeat_count}, 13'h0015);
        issue(16'h4c55);
        chk("mv", {dec.low_half, dec.move_reg_select}, 7'h45);
        issue(16'h40f1);
        chk("mvr", dec.undefined, 1'b1);
        issue(16'hf6a7);
        chk("dir", {dec.direct_read, dec.direct_reg_select}, 5'h1a);
        chk("off", {dec.op_class, dec.direct_offset}, {did_cls_direct, 8'h07});
        issue(16'h1d55);
        for (int i = 0; i < 4; i++) begin
            issue({4'h9, i[1], 2'b00, 4'h5, i[0] ? 5'h1d : 5'h1c});
            chk("sf", dec.special_function, 4'h5);
        end
        $display("test move done");
    endtask : t_move
    task automatic t_pair();
        pair(16'h5000, 16'h1234, 2);
        chk("li", {dec.op_class, dec.long_immediate}, {did_cls_long_imm, 16'h1234});
        pair(16'hc1a1, 16'hffff, 0);
        chk("f3", {dec.op_class, dec.three_operand_function}, 8'h5d);
        pair(16'hf198, 16'h0001, 1);
        chk("ar", {dec.op_class, dec.aux_reg_select}, 8'h88);
        $display("test pair done");
    endtask : t_pair
    task automatic t_qual();
        issue(16'hd00e);
        chk("cc", dec.condition_select, 5'h0e);
        issue(16'h0123);
        chk("qb", dec.undefined, 1'b0);
        issue(16'hd00e);
        issue(16'hfcd3);
        chk("qn", dec.undefined, 1'b1);
        issue(16'hd40e);
        issue(16'hfcd3);
        chk("si", dec.undefined, 1'b0);
        $display("test qualifier done");
    endtask : t_qual
    initial begin
        t_reset();
        t_branch();
        t_mac();
        t_move();
        t_pair();
        t_qual();
        t_reset();
        results();
    end
    // Tests need about 3 us
    initial begin
        #20us;
        errors++;
        results();
    end
endmodule : did_decoder_tb
